// ===== hw/rx_sample_fifo.sv
module rx_sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_idx];
  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop = ce_in && out_valid_out && out_ready_in;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
    bump = (idx == AW'(DEPTH - 1)) ? '0 : AW'(idx + 1'b1);
  endfunction

  always_ff @(posedge core_clk_in)
  begin
    if (push)
    begin
      mem[wr_idx] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx <= bump(wr_idx);
      end
      if (pop)
      begin
        rd_idx <= bump(rd_idx);
      end
      if (push && !pop)
      begin
        count <= CW'(count + 1'b1);
      end
      else if (pop && !push)
      begin
        count <= CW'(count - 1'b1);
      end
    end
  end
endmodule

// ===== hw/serial_rx_ch5_ch6_routing.sv
module serial_rx_ch5_ch6_routing #(
  parameter int WORD_BITS = 32
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] format_in,
  input wire logic bclk_in,
  input wire logic fsync_in,
  input wire logic sdin_in,
  input wire logic dest_ready_in,
  output serial_rx_route_pkg::sample_port_t playback5_out,
  output serial_rx_route_pkg::sample_port_t playback6_out,
  output serial_rx_route_pkg::sample_port_t loopback_adc1_out,
  output serial_rx_route_pkg::sample_port_t loopback_adc2_out,
  output serial_rx_route_pkg::sample_port_t link_dev1_out,
  output logic overrun_out
);
  import serial_rx_route_pkg::*;

  chan_cfg_t cfg5;
  chan_cfg_t cfg6;
  logic [SYNC_STAGES-1:0] bclk_sync;
  logic [SYNC_STAGES-1:0] fsync_sync;
  logic [SYNC_STAGES-1:0] sdin_sync;
  logic bclk_prev;
  logic fs_prev;
  logic i2s_pend;
  logic framed;
  logic half;
  logic [4:0] bit_cnt;
  logic [5:0] slot_cnt;
  logic [SAMPLE_BITS-1:0] shreg;
  logic rise;
  logic fs;
  logic start;
  logic next_half;
  logic [4:0] bit_now;
  logic [5:0] slot_now;
  logic half_now;
  logic [SAMPLE_BITS-1:0] shift_now;
  logic word_done;
  logic ch5_on;
  logic ch6_on;
  logic hit5;
  logic hit6;
  rx_entry_t pend_entry;
  logic pend_valid;
  rx_entry_t push_entry;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic [ENTRY_BITS-1:0] pop_bits;
  rx_entry_t pop_entry;
  logic pop;
  logic [2:0] pop_dest;
  sample_port_t dest [DEST_COUNT];
  logic seen_wr;

  function automatic logic slot_hit(input logic [4:0] idx, input logic [1:0] fmt,
                                    input logic [5:0] slot, input logic rhalf);
    if (fmt == FMT_TDM)
      slot_hit = ({1'b0, idx} == slot);
    else
      slot_hit = (idx[4] == rhalf) && ({2'b00, idx[3:0]} == slot);
  endfunction

  function automatic logic [2:0] dest_of(input logic chan6, input source_t src);
    unique case ({chan6, src})
      {1'b0, SRC_PLAYBACK}: dest_of = DEST_PB5;
      {1'b0, SRC_LOOPBACK}: dest_of = DEST_LB_ADC1;
      {1'b1, SRC_PLAYBACK}: dest_of = DEST_PB6;
      {1'b1, SRC_LOOPBACK}: dest_of = DEST_LB_ADC2;
      {1'b1, SRC_LINK}: dest_of = DEST_LINK1;
      default: dest_of = DEST_NONE; // Off, or the reserved channel 5 code
    endcase
  endfunction

  // Register port: reserved bit forced to zero on write
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cfg5 <= chan_cfg_t'(CH5_CFG_RESET);
      cfg6 <= chan_cfg_t'(CH6_CFG_RESET);
      seen_wr <= 1'b0;
    end
    else if (ce_in && reg_wr_in)
    begin
      if (reg_addr_in == CH5_CFG_OFFSET)
      begin
        cfg5 <= chan_cfg_t'(reg_wdata_in & CFG_WRITE_MASK);
        seen_wr <= 1'b1;
      end
      if (reg_addr_in == CH6_CFG_OFFSET)
      begin
        cfg6 <= chan_cfg_t'(reg_wdata_in & CFG_WRITE_MASK);
        seen_wr <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (ce_in && reg_rd_in)
    begin
      if (reg_addr_in == CH5_CFG_OFFSET)
        reg_rdata_out <= cfg5;
      else if (reg_addr_in == CH6_CFG_OFFSET)
        reg_rdata_out <= cfg6;
      else
        reg_rdata_out <= 8'h00;
    end
  end

  // Pin synchronisers
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bclk_sync <= '0;
      fsync_sync <= '0;
      sdin_sync <= '0;
      bclk_prev <= 1'b0;
    end
    else if (ce_in)
    begin
      bclk_sync <= {bclk_sync[SYNC_STAGES-2:0], bclk_in};
      fsync_sync <= {fsync_sync[SYNC_STAGES-2:0], fsync_in};
      sdin_sync <= {sdin_sync[SYNC_STAGES-2:0], sdin_in};
      bclk_prev <= bclk_sync[SYNC_STAGES-1];
    end
  end

  assign rise = ce_in && bclk_sync[SYNC_STAGES-1] && !bclk_prev;
  assign fs = fsync_sync[SYNC_STAGES-1];

  // Frame boundary: TDM on sync rise, LJ on any sync edge, I2S one bit after the edge
  always_comb
  begin
    start = 1'b0;
    next_half = 1'b0;
    unique case (format_t'(format_in))
      FMT_TDM: start = fs && !fs_prev;
      FMT_I2S:
      begin
        start = i2s_pend;
        next_half = fs;
      end
      FMT_LJ:
      begin
        start = (fs != fs_prev);
        next_half = !fs;
      end
      default: start = 1'b0;
    endcase
  end

  assign bit_now = start ? 5'h00 : bit_cnt;
  assign slot_now = start ? 6'h00 : slot_cnt;
  assign half_now = start ? next_half : half;
  // Each slot restarts from zero so its word lands right-aligned, free of earlier slots
  assign shift_now = (bit_now == 5'h00) ? {{(SAMPLE_BITS-1){1'b0}}, sdin_sync[SYNC_STAGES-1]}
                                        : {shreg[SAMPLE_BITS-2:0], sdin_sync[SYNC_STAGES-1]};
  assign word_done = rise && (framed || start) && (bit_now == 5'(WORD_BITS - 1));

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fs_prev <= 1'b0;
      i2s_pend <= 1'b0;
      framed <= 1'b0;
      half <= 1'b0;
      bit_cnt <= 5'h00;
      slot_cnt <= 6'h00;
      shreg <= '0;
    end
    else if (rise)
    begin
      fs_prev <= fs;
      i2s_pend <= (fs != fs_prev);
      framed <= framed || start;
      half <= half_now;
      shreg <= shift_now;
      bit_cnt <= word_done ? 5'h00 : 5'(bit_now + 1'b1);
      if (word_done && slot_now != 6'h3F)
        slot_cnt <= 6'(slot_now + 1'b1);
      else
        slot_cnt <= slot_now;
    end
  end

  // Only an enabled channel captures; the reserved channel 5 code captures nothing
  assign ch5_on = dest_of(1'b0, cfg5.source) != DEST_NONE;
  assign ch6_on = dest_of(1'b1, cfg6.source) != DEST_NONE;
  assign hit5 = word_done && ch5_on && slot_hit(cfg5.slot, format_in, slot_now, half_now);
  assign hit6 = word_done && ch6_on && slot_hit(cfg6.slot, format_in, slot_now, half_now);

  // Both channels on one slot: channel 6 follows a cycle later
  always_comb
  begin
    push_valid = 1'b1;
    push_entry = pend_entry;
    if (pend_valid)
      push_entry = pend_entry;
    else if (hit5)
      push_entry = '{chan6: 1'b0, source: cfg5.source, data: shift_now};
    else if (hit6)
      push_entry = '{chan6: 1'b1, source: cfg6.source, data: shift_now};
    else
      push_valid = 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pend_valid <= 1'b0;
      pend_entry <= '0;
      overrun_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pend_valid <= hit5 && hit6 && !pend_valid;
      pend_entry <= '{chan6: 1'b1, source: cfg6.source, data: shift_now};
      overrun_out <= push_valid && !push_ready;
    end
  end

  rx_sample_fifo #(
    .WIDTH(ENTRY_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_entry),
    .out_valid_out(pop_valid),
    .out_ready_in(dest_ready_in),
    .out_data_out(pop_bits)
  );

  assign pop_entry = rx_entry_t'(pop_bits);
  assign pop = ce_in && pop_valid && dest_ready_in;
  assign pop_dest = dest_of(pop_entry.chan6, pop_entry.source);

  // Destinations: zero while their channel is not routed to them
  for (genvar i = 0; i < DEST_COUNT; i++)
  begin : g_dest
    logic active;
    assign active = (dest_of(1'b0, cfg5.source) == 3'(i)) || (dest_of(1'b1, cfg6.source) == 3'(i));
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        dest[i] <= '0;
      end
      else if (ce_in)
      begin
        dest[i].valid <= pop && active && (pop_dest == 3'(i));
        if (!active)
          dest[i].data <= '0;
        else if (pop && pop_dest == 3'(i))
          dest[i].data <= pop_entry.data;
      end
    end
  end

  assign playback5_out = dest[DEST_PB5];
  assign loopback_adc1_out = dest[DEST_LB_ADC1];
  assign playback6_out = dest[DEST_PB6];
  assign loopback_adc2_out = dest[DEST_LB_ADC2];
  assign link_dev1_out = dest[DEST_LINK1];

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_pop_to(logic [2:0] d);
    pop && pop_dest == d;
  endsequence

  a_ch5_reset_value: assert property (!seen_wr |-> cfg5 == chan_cfg_t'(CH5_CFG_RESET))
    else $error("channel 5 config left its reset value without a write");
  a_ch6_reset_value: assert property (!seen_wr |-> cfg6 == chan_cfg_t'(CH6_CFG_RESET))
    else $error("channel 6 config left its reset value without a write");
  a_reserved_reads_zero: assert property (!cfg5.reserved && !cfg6.reserved && !reg_rdata_out[RESERVED_BIT])
    else $error("reserved bit seen as one");
  a_ch5_playback_route: assert property (s_pop_to(DEST_PB5) ##0 cfg5.source == SRC_PLAYBACK
    |=> playback5_out.valid && playback5_out.data == $past(pop_entry.data))
    else $error("channel 5 sample did not reach playback 5");
  a_ch5_adc1_loop: assert property (s_pop_to(DEST_LB_ADC1) ##0 cfg5.source == SRC_LOOPBACK
    |=> loopback_adc1_out.valid && !loopback_adc2_out.valid)
    else $error("channel 5 loopback not delivered to ADC 1 path");
  a_ch6_adc2_loop: assert property (s_pop_to(DEST_LB_ADC2) ##0 cfg6.source == SRC_LOOPBACK
    |=> loopback_adc2_out.valid && loopback_adc2_out.data == $past(pop_entry.data))
    else $error("channel 6 loopback not delivered to ADC 2 path");
  a_ch6_link_dev: assert property (s_pop_to(DEST_LINK1) ##0 cfg6.source == SRC_LINK
    |=> link_dev1_out.valid && !playback6_out.valid)
    else $error("channel 6 link data misrouted");
  a_ch6_playback_route: assert property (s_pop_to(DEST_PB6) ##0 cfg6.source == SRC_PLAYBACK
    |=> playback6_out.valid)
    else $error("channel 6 sample did not reach playback 6");
  a_disabled_gives_zero: assert property (ce_in && cfg5.source == SRC_OFF ##1 ce_in && cfg5.source == SRC_OFF
    |-> playback5_out.data == '0 && !playback5_out.valid && !loopback_adc1_out.valid)
    else $error("disabled channel 5 still delivers data");
  a_tdm_slot_capture: assert property (word_done && format_in == FMT_TDM && ch5_on && !pend_valid
    && slot_now == {1'b0, cfg5.slot} |-> push_valid && !push_entry.chan6)
    else $error("TDM slot match did not capture channel 5");
  a_i2s_half_capture: assert property (word_done && format_in != FMT_TDM && ch6_on && !hit5 && !pend_valid
    && half_now == cfg6.slot[4] && slot_now == {2'b00, cfg6.slot[3:0]} |-> push_valid && push_entry.chan6)
    else $error("two-half slot match did not capture channel 6");
endmodule

// ===== hw/serial_rx_route_pkg.sv
package serial_rx_route_pkg;
  localparam logic [7:0] CH5_CFG_OFFSET = 8'h2C;
  localparam logic [7:0] CH6_CFG_OFFSET = 8'h2D;
  localparam logic [7:0] CH5_CFG_RESET = 8'h04;
  localparam logic [7:0] CH6_CFG_RESET = 8'h05;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h7F;
  localparam int RESERVED_BIT = 7;
  localparam int SOURCE_MSB = 6;
  localparam int SOURCE_LSB = 5;
  localparam int SLOT_MSB = 4;
  localparam int SLOT_LSB = 0;
  localparam int SAMPLE_BITS = 32;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    SRC_OFF = 2'b00,
    SRC_PLAYBACK = 2'b01,
    SRC_LOOPBACK = 2'b10,
    SRC_LINK = 2'b11
  } source_t;

  typedef enum logic [1:0] {
    FMT_TDM = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LJ = 2'b10
  } format_t;

  typedef struct packed {
    logic reserved;
    source_t source;
    logic [4:0] slot;
  } chan_cfg_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_BITS-1:0] data;
  } sample_port_t;

  typedef struct packed {
    logic chan6;
    source_t source;
    logic [SAMPLE_BITS-1:0] data;
  } rx_entry_t;

  localparam int ENTRY_BITS = $bits(rx_entry_t);
  localparam int DEST_COUNT = 5;
  localparam logic [2:0] DEST_PB5 = 3'h0;
  localparam logic [2:0] DEST_LB_ADC1 = 3'h1;
  localparam logic [2:0] DEST_PB6 = 3'h2;
  localparam logic [2:0] DEST_LB_ADC2 = 3'h3;
  localparam logic [2:0] DEST_LINK1 = 3'h4;
  localparam logic [2:0] DEST_NONE = 3'h7;
endpackage

// ===== verification/audio_host_model.sv
module audio_host_model #(
  parameter int WORD_BITS = 8
) (
  output logic bclk_out,
  output logic fsync_out,
  output logic sdin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import serial_rx_route_pkg::*;

  initial
  begin
    bclk_out = 1'b0;
    fsync_out = 1'b0;
    sdin_out = 1'b0;
  end

  // Bit clock runs only inside a frame; two lead bits give every format a clean boundary
  task automatic send_frame(input logic [1:0] fmt);
    int n;
    logic [31:0] w;
    logic fs;
    n = 32 * WORD_BITS;
    #13;
    for (int j = -2; j < n; j++)
    begin
      case (fmt)
        FMT_TDM: fs = (j == 0);
        FMT_LJ: fs = (j >= 0) && (j < n / 2);
        default: fs = (j == -2) || (j == n - 1) || (j + 1 >= n / 2);
      endcase
      fsync_out = fs;
      if (j < 0)
        sdin_out = ~sdin_out;
      else
      begin
        w = 32'({3'b101, 5'(j / WORD_BITS)});
        sdin_out = w[WORD_BITS - 1 - (j % WORD_BITS)];
      end
      #160 bclk_out = 1'b1;
      #160 bclk_out = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    sdin_out = ~sdin_out;
  endtask
endmodule

// ===== verification/tb_serial_rx_ch5_ch6_routing.sv
module tb_serial_rx_ch5_ch6_routing;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_rx_route_pkg::*;

  localparam int W = 8;
  logic core_clk, rstn, reg_wr, reg_rd, bclk, fsync, sdin, dest_ready, overrun;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] fmt;
  sample_port_t pb5, pb6, lb1, lb2, link1;
  int errors = 0;
  int n_tests = 0;
  int overruns = 0;
  logic [31:0] got [5][$];

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  serial_rx_ch5_ch6_routing #(.WORD_BITS(W)) DUT (
    .core_clk_in(core_clk), .rstn_in(rstn), .ce_in(1'b1), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .format_in(fmt),
    .bclk_in(bclk), .fsync_in(fsync), .sdin_in(sdin), .dest_ready_in(dest_ready),
    .playback5_out(pb5), .playback6_out(pb6), .loopback_adc1_out(lb1), .loopback_adc2_out(lb2),
    .link_dev1_out(link1), .overrun_out(overrun)
  );

  audio_host_model #(.WORD_BITS(W)) host (.bclk_out(bclk), .fsync_out(fsync), .sdin_out(sdin));

  always @(posedge core_clk)
  begin
    if (pb5.valid === 1'b1) got[0].push_back(pb5.data);
    if (lb1.valid === 1'b1) got[1].push_back(lb1.data);
    if (pb6.valid === 1'b1) got[2].push_back(pb6.data);
    if (lb2.valid === 1'b1) got[3].push_back(lb2.data);
    if (link1.valid === 1'b1) got[4].push_back(link1.data);
    if (overrun === 1'b1) overruns++;
  end

  function automatic logic [31:0] word_of(input int s);
    return {24'h0, 3'b101, s[4:0]};
  endfunction

  task automatic give_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    check({24'h0, reg_rdata}, {24'h0, exp}, "register read");
  endtask

  task automatic run_frame(input logic [1:0] f);
    for (int d = 0; d < 5; d++)
      got[d].delete();
    @(posedge core_clk);
    fmt <= f;
    @(posedge core_clk);
    host.send_frame(f);
    repeat (40) @(posedge core_clk);
    #1;
  endtask

  task automatic expect_dest(input int d, input int n, input logic [31:0] w);
    check(32'(got[d].size()), 32'(n), "sample count");
    if (n > 0)
      check(got[d][0], w, "sample data");
  endtask

  // Both channels disabled out of reset: nothing reaches any destination
  task automatic t_idle();
    run_frame(FMT_TDM);
    for (int d = 0; d < 5; d++)
      expect_dest(d, 0, 32'h0);
    check(pb5.data, 32'h0, "idle data");
  endtask

  task automatic t_regs();
    reg_read(CH5_CFG_OFFSET, 8'h04);
    reg_read(CH6_CFG_OFFSET, 8'h05);
    reg_read(8'h2E, 8'h00);
    // Software keeps the reserved bit at zero and never writes the reserved channel 5 code
    reg_write(CH5_CFG_OFFSET, 8'h00);
    reg_read(CH5_CFG_OFFSET, 8'h00);
    reg_write(CH6_CFG_OFFSET, 8'h7F);
    reg_read(CH6_CFG_OFFSET, 8'h7F);
  endtask

  // Extreme TDM slots 0 and 31
  task automatic t_tdm_edges();
    reg_write(CH5_CFG_OFFSET, 8'h20);
    reg_write(CH6_CFG_OFFSET, 8'h5F);
    run_frame(FMT_TDM);
    expect_dest(0, 1, word_of(0));
    expect_dest(3, 1, word_of(31));
    expect_dest(1, 0, 32'h0);
    expect_dest(2, 0, 32'h0);
    check(pb5.data, word_of(0), "held data");
    check(link1.data, 32'h0, "unrouted data");
  endtask

  // Both channels capture the same slot
  task automatic t_shared_slot();
    reg_write(CH5_CFG_OFFSET, 8'h43);
    reg_write(CH6_CFG_OFFSET, 8'h63);
    run_frame(FMT_TDM);
    expect_dest(1, 1, word_of(3));
    expect_dest(4, 1, word_of(3));
    expect_dest(0, 0, 32'h0);
    check(pb5.data, 32'h0, "unrouted data");
  endtask

  // Channel 5 parked off on the slot that channel 6 plays; then format code 3 finds no frame
  task automatic t_reserved();
    reg_write(CH5_CFG_OFFSET, 8'h09);
    reg_write(CH6_CFG_OFFSET, 8'h29);
    run_frame(FMT_TDM);
    expect_dest(2, 1, word_of(9));
    expect_dest(0, 0, 32'h0);
    expect_dest(1, 0, 32'h0);
    expect_dest(4, 0, 32'h0);
    check(link1.data, 32'h0, "unrouted data");
    run_frame(2'b11);
    expect_dest(2, 0, 32'h0);
    check(pb6.data, word_of(9), "held data");
  endtask

  // Index 17 is right slot 1 and 15 is left slot 15 in both half formats
  task automatic t_half_formats();
    reg_write(CH5_CFG_OFFSET, 8'h31);
    reg_write(CH6_CFG_OFFSET, 8'h2F);
    for (int k = 0; k < 2; k++)
    begin
      run_frame(k == 0 ? FMT_I2S : FMT_LJ);
      expect_dest(0, 1, word_of(17));
      expect_dest(2, 1, word_of(15));
    end
  endtask

  // Stalled destination: two frames fill the buffer, the third is dropped
  task automatic t_overrun();
    reg_write(CH5_CFG_OFFSET, 8'h22);
    reg_write(CH6_CFG_OFFSET, 8'h44);
    @(posedge core_clk);
    dest_ready <= 1'b0;
    overruns = 0;
    run_frame(FMT_TDM);
    host.send_frame(FMT_TDM);
    host.send_frame(FMT_TDM);
    repeat (40) @(posedge core_clk);
    check(32'(overruns), 32'd2, "overrun pulses");
    expect_dest(0, 0, 32'h0);
    dest_ready <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    expect_dest(0, 2, word_of(2));
    expect_dest(3, 2, word_of(4));
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    rstn <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    fmt <= FMT_TDM;
    dest_ready <= 1'b1;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    t_idle();
    t_regs();
    t_tdm_edges();
    t_shared_slot();
    t_reserved();
    t_half_formats();
    t_overrun();
    give_verdict();
  end
endmodule
